// >>> bench/ssp_link_chk.sv
`timescale 1ns/1ps
`default_nettype none
module ssp_link_chk (
  input wire logic mclk,
  input wire logic srst,
  input wire logic sclk,
  input wire logic sdata,
  input wire logic load_strobe,
  input wire logic chip_enable
);
  // ----------------------------------------------------------------
  // sclk rises since the last strobe rise
  // ----------------------------------------------------------------
  logic [5:0] rise_cnt;
  logic       sclk_q;
  logic       strobe_q;

  always_ff @(posedge mclk) begin
    if (srst) begin
      rise_cnt <= 6'h00;
      sclk_q   <= 1'b0;
      strobe_q <= 1'b0;
    end else begin
      sclk_q   <= sclk;
      strobe_q <= load_strobe;
      if (load_strobe && !strobe_q) begin
        rise_cnt <= 6'h00;
      end else if (sclk && !sclk_q && rise_cnt != 6'h3f) begin
        rise_cnt <= rise_cnt + 6'h01;
      end
    end
  end

  default clocking @(posedge mclk); endclocking
  default disable iff (srst);

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  chk_sclk_high_len: assert property ($rose(sclk) |-> sclk[*5] ##1 !sclk)
    else $error("serial clock high phase is not five cycles");
  chk_sclk_low_len: assert property ($fell(sclk) |-> !sclk[*5])
    else $error("serial clock low phase shorter than five cycles");
  chk_data_stable: assert property (sclk |-> $stable(sdata))
    else $error("serial data moved while serial clock high");
  chk_word_bits: assert property ($rose(load_strobe) |-> rise_cnt == 6'd32)
    else $error("strobe rose without exactly 32 bits shifted");
  chk_bit_overrun: assert property (rise_cnt <= 6'd32)
    else $error("more than 32 bits shifted before a strobe");
  chk_word_then_load: assert property ($fell(sclk) && rise_cnt == 6'd32 |-> load_strobe)
    else $error("strobe did not follow the last bit");
  chk_strobe_len: assert property ($rose(load_strobe) |-> load_strobe[*4] ##1 !load_strobe)
    else $error("strobe high time is not four cycles");
  chk_strobe_sclk_low: assert property (load_strobe |-> !sclk)
    else $error("serial clock high during strobe");
  chk_strobe_quiet_after: assert property ($fell(load_strobe) |-> !sclk[*3])
    else $error("serial clock rose right after strobe");

  cov_load: cover property ($rose(load_strobe));
  cov_bit: cover property ($rose(sclk) && sdata);
  cov_enable: cover property ($rose(chip_enable));
endmodule
`default_nettype wire

// >>> bench/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic        mclk, srst, word_valid, word_ready, chip_enable_req;
  logic [31:0] word_data;
  logic        ref_edge, fb_edge, ana_lock, dig_lock, seen;
  logic [11:0] int_value, frac_value, phase_value, denominator_value, clock_divider_word_tag_value;
  logic [3:0]  output_select, pump_current_code;
  logic [5:0]  ref_ratio;
  logic [6:0]  pfd_div;
  logic [1:0]  pfd_mult, aux_mode, clock_divider_word_tag_mode;
  logic        doubler, reference_halver_bit, slip_reduction_enable, prescaler_sel;
  logic        counter_reset, power_down, pump_tristate, pfd_polarity, lock_window_select;
  logic        sd_reset, int_bad, denom_bad, frac_bad, pfd_up, pfd_dn;
  logic        observation_pin, observation_oe_n;
  int          bad_count, comparisons;
  logic [3:0]  oc [8];
  logic        ex [8];

  ssp_serial_if link ();
  ssp_host ssp_host_inst (.mclk, .srst, .word_data, .word_valid, .word_ready,
    .chip_enable_req, .link(link));
  ssp_device ssp_device_inst (.mclk, .srst, .link(link), .ref_edge, .fb_edge, .ana_lock,
    .dig_lock, .int_value, .frac_value, .output_select, .phase_value, .denominator_value,
    .ref_ratio, .doubler, .reference_halver_bit, .pump_current_code, .slip_reduction_enable,
    .prescaler_sel, .aux_mode, .pfd_mult, .pfd_div, .counter_reset, .power_down,
    .pump_tristate, .pfd_polarity, .lock_window_select, .sd_reset, .clock_divider_word_tag_value,
    .clock_divider_word_tag_mode, .int_bad, .denom_bad, .frac_bad, .pfd_up, .pfd_dn, .observation_pin,
    .observation_oe_n);
  ssp_link_chk ssp_link_chk_inst (.mclk(mclk), .srst(srst), .sclk(link.sclk),
    .sdata(link.sdata), .load_strobe(link.load_strobe), .chip_enable(link.chip_enable));

  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic tick(input int n);
    repeat (n) begin
      @(posedge mclk);
      #1;
    end
  endtask

  task automatic check(input string name, input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic conclude;
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // bounded: a stuck host ends the run instead of hanging it
  task automatic wait_ready;
    int i;
    i = 0;
    while (word_ready !== 1'b1 && i < 400) begin
      tick(1);
      i++;
    end
    if (i >= 400) begin
      bad_count++;
      $display("[ERR] word_ready expected 1 seen stuck");
      conclude();
    end
  endtask

  // whole word out, then two cycles so the observation pin settles
  task automatic send(input logic [31:0] w);
    wait_ready();
    word_data  = w;
    word_valid = 1'b1;
    tick(1);
    word_valid = 1'b0;
    tick(2);
    wait_ready();
    tick(2);
  endtask

  function automatic logic [31:0] w_div(input logic [3:0] os, input logic [11:0] iv);
    return {1'b0, os, iv, 12'h005, ssp_pkg::SEL_DIVIDE};
  endfunction

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    srst = 1'b1; word_valid = 1'b0; word_data = 32'h0; chip_enable_req = 1'b0;
    ref_edge = 1'b0; fb_edge = 1'b0; ana_lock = 1'b1; dig_lock = 1'b0;
    bad_count = 0; comparisons = 0;
    oc = '{4'h0, 4'h1, 4'h2, 4'h5, 4'h6, 4'h7, 4'hd, 4'he};
    ex = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1};
    tick(10);
    srst = 1'b0;
    tick(1);
    check("ref_ratio", ref_ratio, 32'h20);
    check("power_down", power_down, 32'h1);
    check("pump_tristate", pump_tristate, 32'h1);
    chip_enable_req = 1'b1;
    tick(3);
    check("power_down", power_down, 32'h0);
    send(w_div(4'h1, 12'h017));
    check("int_value", int_value, 32'h17);
    check("frac_value", frac_value, 32'h5);
    check("output_select", output_select, 32'h1);
    check("int_bad", int_bad, 32'h0);
    check("frac_bad", frac_bad, 32'h1);
    check("denom_bad", denom_bad, 32'h1);
    // one below the floor must raise the flag again after it was clear
    send(w_div(4'h1, 12'h016));
    check("int_bad", int_bad, 32'h1);
    // reference word: direct fields now, buffered ones wait
    send({1'b0, 2'h2, 1'b1, 4'h5, 1'b0, 1'b1, 1'b1, 1'b1, 5'h03, 12'h064, 3'h2});
    check("slip", slip_reduction_enable, 32'h1);
    check("prescaler", prescaler_sel, 32'h1);
    check("aux_mode", aux_mode, 32'h2);
    check("denominator", denominator_value, 32'h0);
    check("ref_ratio", ref_ratio, 32'h20);
    check("pump", pump_current_code, 32'h0);
    send({17'h0, 12'habc, 3'h1});
    check("phase", phase_value, 32'h0);
    send(w_div(4'h1, 12'h017));
    check("phase", phase_value, 32'habc);
    check("denominator", denominator_value, 32'h64);
    check("ref_ratio", ref_ratio, 32'h3);
    check("pfd_div", pfd_div, 32'h6);
    check("pfd_mult", pfd_mult, 32'h2);
    check("doubler", doubler, 32'h1);
    check("halver", reference_halver_bit, 32'h1);
    check("pump", pump_current_code, 32'h5);
    check("frac_bad", frac_bad, 32'h0);
    check("denom_bad", denom_bad, 32'h0);
    // unused select codes load nothing
    for (int c = 5; c < 8; c++) begin
      send({29'h1fff_ffff, 3'(c)});
      check("int_value", int_value, 32'h17);
      check("phase", phase_value, 32'habc);
      check("clock_divider_word_tag", clock_divider_word_tag_value, 32'h0);
    end
    ref_edge = 1'b1;
    tick(1);
    ref_edge = 1'b0;
    tick(1);
    check("pfd_up", pfd_up, 32'h1);
    check("pfd_dn", pfd_dn, 32'h0);
    fb_edge = 1'b1;
    tick(1);
    fb_edge = 1'b0;
    seen = 1'b0;
    repeat (4) begin
      seen = seen | pfd_dn;
      tick(1);
    end
    check("pfd_dn_seen", seen, 32'h1);
    check("pfd_up", pfd_up, 32'h0);
    check("pfd_dn", pfd_dn, 32'h0);
    // one reference and one feedback pulse so far: both halved outputs sit high
    for (int i = 0; i < 8; i++) begin
      send(w_div(oc[i], 12'h017));
      check("obs_oe_n", observation_oe_n, 32'(i == 0));
      if (i > 0) check("obs_pin", observation_pin, 32'(ex[i]));
    end
    send(32'h0000_40cb);
    check("counter_reset", counter_reset, 32'h1);
    check("pfd_polarity", pfd_polarity, 32'h1);
    check("lock_window", lock_window_select, 32'h1);
    check("sd_reset", sd_reset, 32'h1);
    check("pump_tristate", pump_tristate, 32'h0);
    send({11'h0, 2'h3, 12'h5a5, 4'h0, 3'h4});
    check("clock_divider_word_tag", clock_divider_word_tag_value, 32'h5a5);
    check("clock_divider_word_tag_mode", clock_divider_word_tag_mode, 32'h3);
    check("int_value", int_value, 32'h17);
    chip_enable_req = 1'b0;
    tick(3);
    check("power_down", power_down, 32'h1);
    check("pump_tristate", pump_tristate, 32'h1);
    // pump three-state bit alone, then the power-down bit
    chip_enable_req = 1'b1;
    send(32'h0000_0013);
    check("power_down", power_down, 32'h0);
    check("pump_tristate", pump_tristate, 32'h1);
    send(32'h0000_0023);
    check("power_down", power_down, 32'h1);
    check("pump_tristate", pump_tristate, 32'h1);
    conclude();
  end
endmodule
`default_nettype wire

// >>> common/ssp_pkg.sv
`default_nettype none
package ssp_pkg;

  // ----------------------------------------------------------------
  // word layout
  // ----------------------------------------------------------------
  localparam int WORD_W = 32;
  localparam int SEL_LSB = 0;
  localparam int SEL_W = 3;
  localparam logic [2:0] SEL_DIVIDE = 3'h0;
  localparam logic [2:0] SEL_PHASE = 3'h1;
  localparam logic [2:0] SEL_REFPATH = 3'h2;
  localparam int SEL_FUNCTION = 3;
  localparam int SEL_CLOCK_DIVIDER_WORD_TAG = 4;
  localparam int NUM_LATCH = 5;

  localparam int FRAC_LSB = 3;
  localparam int VAL12_W = 12;
  localparam int INT_LSB = 15;
  localparam int OSEL_LSB = 27;
  localparam int OSEL_W = 4;
  localparam int PHASE_LSB = 3;
  localparam int DENOM_LSB = 3;
  localparam int RCNT_LSB = 15;
  localparam int RCNT_W = 5;
  localparam int DOUBLER_POS = 20;
  localparam int HALVER_POS = 21;
  localparam int PRESCALER_POS = 22;
  localparam int PUMP_LSB = 24;
  localparam int PUMP_W = 4;
  localparam int SLIP_POS = 28;
  localparam int AUX_LSB = 29;
  localparam int AUX_W = 2;
  localparam int CNT_RESET_POS = 3;
  localparam int CP_TRI_POS = 4;
  localparam int PWR_DOWN_POS = 5;
  localparam int PD_POL_POS = 6;
  localparam int LOCK_WIN_POS = 7;
  localparam int SD_RESET_POS = 14;
  localparam int CLOCK_DIVIDER_WORD_TAG_LSB = 7;
  localparam int CLKMODE_LSB = 19;
  localparam int CLKMODE_W = 2;

  localparam logic [31:0] WORD_RESET = 32'h0000_0000;

  // ----------------------------------------------------------------
  // legal ranges
  // ----------------------------------------------------------------
  localparam logic [11:0] INT_MIN = 12'h017;
  localparam logic [11:0] DENOM_MIN = 12'h002;
  localparam logic [5:0] REF_RATIO_MAX = 6'h20;

  // ----------------------------------------------------------------
  // observation select codes
  // ----------------------------------------------------------------
  localparam logic [3:0] OSEL_TRISTATE = 4'h0;
  localparam logic [3:0] OSEL_HIGH = 4'h1;
  localparam logic [3:0] OSEL_LOW = 4'h2;
  localparam logic [3:0] OSEL_REF_DIV = 4'h3;
  localparam logic [3:0] OSEL_FB_DIV = 4'h4;
  localparam logic [3:0] OSEL_ANA_LOCK = 4'h5;
  localparam logic [3:0] OSEL_DIG_LOCK = 4'h6;
  localparam logic [3:0] OSEL_REF_HALF = 4'hd;
  localparam logic [3:0] OSEL_FB_HALF = 4'he;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_PS = 5000;
  localparam int ABL_PS = 3000;
  localparam int ABL_CYC = (ABL_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int SCLK_HALF_PS = 25000;
  localparam int SCLK_HALF_CYC = (SCLK_HALF_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int STRB_HIGH_PS = 20000;
  localparam int STRB_HIGH_CYC = (STRB_HIGH_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int TMR_W = 4;
  localparam int BIT_W = 5;

endpackage
`default_nettype wire

// >>> common/ssp_serial_if.sv
`timescale 1ns/1ps
`default_nettype none
interface ssp_serial_if;
  logic sclk;
  logic sdata;
  logic load_strobe;
  logic chip_enable;

  modport host (
    output sclk,
    output sdata,
    output load_strobe,
    output chip_enable
  );

  modport dev (
    input sclk,
    input sdata,
    input load_strobe,
    input chip_enable
  );
endinterface
`default_nettype wire

// >>> rtl/ssp_device.sv
`timescale 1ns/1ps
`default_nettype none
module ssp_device (
  input  wire logic        mclk,
  input  wire logic        srst,
  ssp_serial_if.dev        link,
  input  wire logic        ref_edge,
  input  wire logic        fb_edge,
  input  wire logic        ana_lock,
  input  wire logic        dig_lock,
  output logic [11:0]      int_value,
  output logic [11:0]      frac_value,
  output logic [3:0]       output_select,
  output logic [11:0]      phase_value,
  output logic [11:0]      denominator_value,
  output logic [5:0]       ref_ratio,
  output logic             doubler,
  output logic             reference_halver_bit,
  output logic [3:0]       pump_current_code,
  output logic             slip_reduction_enable,
  output logic             prescaler_sel,
  output logic [1:0]       aux_mode,
  output logic [1:0]       pfd_mult,
  output logic [6:0]       pfd_div,
  output logic             counter_reset,
  output logic             power_down,
  output logic             pump_tristate,
  output logic             pfd_polarity,
  output logic             lock_window_select,
  output logic             sd_reset,
  output logic [11:0]      clock_divider_word_tag_value,
  output logic [1:0]       clock_divider_word_tag_mode,
  output logic             int_bad,
  output logic             denom_bad,
  output logic             frac_bad,
  output logic             pfd_up,
  output logic             pfd_dn,
  output logic             observation_pin,
  output logic             observation_oe_n
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [31:0]                    shreg;
    logic                           sclk_q;
    logic                           strobe_q;
    logic [31:0]                    w_div;
    logic [31:0]                    w_phase;
    logic [31:0]                    w_ref;
    logic [31:0]                    w_func;
    logic [31:0]                    w_clk;
    logic [11:0]                    phase_act;
    logic [11:0]                    denom_act;
    logic [4:0]                     rcnt_act;
    logic                           dbl_act;
    logic                           hlv_act;
    logic [3:0]                     pump_act;
    logic [5:0]                     ratio;
    logic [6:0]                     pdiv;
    logic                           int_bad;
    logic                           denom_bad;
    logic                           frac_bad;
    logic                           up;
    logic                           dn;
    logic [3:0]                     abl_cnt;
    logic                           ref_tgl;
    logic                           fb_tgl;
    logic                           obs;
    logic                           obs_oe_n;
  } ssp_dev_state_t;

  localparam logic [3:0] ABL_LAST = 4'(ssp_pkg::ABL_CYC - 1);

  ssp_dev_state_t s;
  ssp_dev_state_t next_s;

  // 5-bit code 0 stands for the top ratio so that 1 to 32 all fit
  function automatic logic [5:0] ssp_ratio(input logic [4:0] code);
    ssp_ratio = (code == 5'h00) ? ssp_pkg::REF_RATIO_MAX : {1'b0, code};
  endfunction

  function automatic logic [11:0] ssp_f12(input logic [31:0] w, input int lsb);
    ssp_f12 = w[lsb +: ssp_pkg::VAL12_W];
  endfunction

  logic load_ev;
  logic [2:0] sel;
  logic [11:0] next_int;
  logic [11:0] next_frac;

  assign load_ev = link.load_strobe && !s.strobe_q;
  assign sel = s.shreg[ssp_pkg::SEL_LSB +: ssp_pkg::SEL_W];

  // ----------------------------------------------------------------
  // serial capture and latches
  // ----------------------------------------------------------------
  always_comb begin
    next_s = s;
    next_s.sclk_q = link.sclk;
    next_s.strobe_q = link.load_strobe;
    if (link.sclk && !s.sclk_q) begin
      next_s.shreg = {s.shreg[30:0], link.sdata};
    end
    // latches move only on a strobe rise; the word was complete before it
    if (load_ev) begin
      case (sel)
        ssp_pkg::SEL_DIVIDE: begin
          next_s.w_div = s.shreg;
          // pending buffered values go live with the divide-setting write
          next_s.phase_act = ssp_f12(s.w_phase, ssp_pkg::PHASE_LSB);
          next_s.denom_act = ssp_f12(s.w_ref, ssp_pkg::DENOM_LSB);
          next_s.rcnt_act = s.w_ref[ssp_pkg::RCNT_LSB +: ssp_pkg::RCNT_W];
          next_s.dbl_act = s.w_ref[ssp_pkg::DOUBLER_POS];
          next_s.hlv_act = s.w_ref[ssp_pkg::HALVER_POS];
          next_s.pump_act = s.w_ref[ssp_pkg::PUMP_LSB +: ssp_pkg::PUMP_W];
        end
        ssp_pkg::SEL_PHASE: next_s.w_phase = s.shreg;
        ssp_pkg::SEL_REFPATH: next_s.w_ref = s.shreg;
        3'(ssp_pkg::SEL_FUNCTION): next_s.w_func = s.shreg;
        3'(ssp_pkg::SEL_CLOCK_DIVIDER_WORD_TAG): next_s.w_clk = s.shreg;
        default: next_s.w_div = s.w_div;
      endcase
    end
    next_int = ssp_f12(next_s.w_div, ssp_pkg::INT_LSB);
    next_frac = ssp_f12(next_s.w_div, ssp_pkg::FRAC_LSB);
    next_s.ratio = ssp_ratio(next_s.rcnt_act);
    next_s.pdiv = next_s.hlv_act ? {next_s.ratio, 1'b0} : {1'b0, next_s.ratio};
    // the host owns the ranges; the flags only report a breach
    next_s.int_bad = (next_int < ssp_pkg::INT_MIN);
    next_s.denom_bad = (next_s.denom_act < ssp_pkg::DENOM_MIN);
    next_s.frac_bad = (next_frac >= next_s.denom_act);

    // ----------------------------------------------------------------
    // phase frequency detector
    // ----------------------------------------------------------------
    if (ref_edge) begin
      next_s.up = 1'b1;
      next_s.ref_tgl = !s.ref_tgl;
    end
    if (fb_edge) begin
      next_s.dn = 1'b1;
      next_s.fb_tgl = !s.fb_tgl;
    end
    // both outputs overlap for a fixed time before clearing: no dead zone
    if (s.up && s.dn) begin
      if (s.abl_cnt == ABL_LAST) begin
        next_s.up = 1'b0;
        next_s.dn = 1'b0;
        next_s.abl_cnt = '0;
      end else begin
        next_s.abl_cnt = s.abl_cnt + 1'b1;
      end
    end
    if (!link.chip_enable || s.w_func[ssp_pkg::CNT_RESET_POS]
        || s.w_func[ssp_pkg::PWR_DOWN_POS]) begin
      next_s.up = 1'b0;
      next_s.dn = 1'b0;
      next_s.abl_cnt = '0;
    end

    // ----------------------------------------------------------------
    // observation pin
    // ----------------------------------------------------------------
    next_s.obs_oe_n = 1'b0;
    case (s.w_div[ssp_pkg::OSEL_LSB +: ssp_pkg::OSEL_W])
      ssp_pkg::OSEL_TRISTATE: begin
        next_s.obs = 1'b0;
        next_s.obs_oe_n = 1'b1;
      end
      ssp_pkg::OSEL_HIGH: next_s.obs = 1'b1;
      ssp_pkg::OSEL_REF_DIV: next_s.obs = ref_edge;
      ssp_pkg::OSEL_FB_DIV: next_s.obs = fb_edge;
      ssp_pkg::OSEL_ANA_LOCK: next_s.obs = ana_lock;
      ssp_pkg::OSEL_DIG_LOCK: next_s.obs = dig_lock;
      ssp_pkg::OSEL_REF_HALF: next_s.obs = s.ref_tgl;
      ssp_pkg::OSEL_FB_HALF: next_s.obs = s.fb_tgl;
      default: next_s.obs = 1'b0;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      s <= '0;
      s.obs_oe_n <= 1'b1;
      s.ratio <= ssp_pkg::REF_RATIO_MAX;
      s.pdiv <= {1'b0, ssp_pkg::REF_RATIO_MAX};
      s.int_bad <= 1'b1;
      s.denom_bad <= 1'b1;
      s.frac_bad <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign int_value = ssp_f12(s.w_div, ssp_pkg::INT_LSB);
  assign frac_value = ssp_f12(s.w_div, ssp_pkg::FRAC_LSB);
  assign output_select = s.w_div[ssp_pkg::OSEL_LSB +: ssp_pkg::OSEL_W];
  assign phase_value = s.phase_act;
  assign denominator_value = s.denom_act;
  assign ref_ratio = s.ratio;
  assign doubler = s.dbl_act;
  assign reference_halver_bit = s.hlv_act;
  assign pump_current_code = s.pump_act;
  assign slip_reduction_enable = s.w_ref[ssp_pkg::SLIP_POS];
  assign prescaler_sel = s.w_ref[ssp_pkg::PRESCALER_POS];
  assign aux_mode = s.w_ref[ssp_pkg::AUX_LSB +: ssp_pkg::AUX_W];
  assign pfd_mult = {1'b0, s.dbl_act} + 2'h1;
  assign pfd_div = s.pdiv;
  assign counter_reset = s.w_func[ssp_pkg::CNT_RESET_POS];
  assign power_down = !link.chip_enable || s.w_func[ssp_pkg::PWR_DOWN_POS];
  assign pump_tristate = power_down || s.w_func[ssp_pkg::CP_TRI_POS];
  assign pfd_polarity = s.w_func[ssp_pkg::PD_POL_POS];
  assign lock_window_select = s.w_func[ssp_pkg::LOCK_WIN_POS];
  assign sd_reset = s.w_func[ssp_pkg::SD_RESET_POS];
  assign clock_divider_word_tag_value = ssp_f12(s.w_clk, ssp_pkg::CLOCK_DIVIDER_WORD_TAG_LSB);
  assign clock_divider_word_tag_mode = s.w_clk[ssp_pkg::CLKMODE_LSB +: ssp_pkg::CLKMODE_W];
  assign int_bad = s.int_bad;
  assign denom_bad = s.denom_bad;
  assign frac_bad = s.frac_bad;
  assign pfd_up = s.up;
  assign pfd_dn = s.dn;
  assign observation_pin = s.obs;
  assign observation_oe_n = s.obs_oe_n;

endmodule
`default_nettype wire

// >>> rtl/ssp_host.sv
`timescale 1ns/1ps
`default_nettype none
module ssp_host (
  input  wire logic        mclk,
  input  wire logic        srst,
  input  wire logic [31:0] word_data,
  input  wire logic        word_valid,
  output logic             word_ready,
  input  wire logic        chip_enable_req,
  ssp_serial_if.host       link
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    SSP_IDLE  = 2'h0,
    SSP_LOW   = 2'h1,
    SSP_HIGH  = 2'h3,
    SSP_LOAD  = 2'h2
  } ssp_host_fsm_t;

  typedef struct packed {
    ssp_host_fsm_t                  fsm;
    logic [31:0]                    shreg;
    logic [ssp_pkg::BIT_W-1:0]      bits_left;
    logic [ssp_pkg::TMR_W-1:0]      tmr;
    logic                           sclk;
    logic                           strobe;
    logic                           ce;
  } ssp_host_state_t;

  localparam logic [ssp_pkg::TMR_W-1:0] HALF_LAST = ssp_pkg::TMR_W'(ssp_pkg::SCLK_HALF_CYC - 1);
  localparam logic [ssp_pkg::TMR_W-1:0] STRB_LAST = ssp_pkg::TMR_W'(ssp_pkg::STRB_HIGH_CYC - 1);

  ssp_host_state_t s;
  ssp_host_state_t next_s;

  // ----------------------------------------------------------------
  // shifting sequence
  // ----------------------------------------------------------------
  always_comb begin
    next_s = s;
    next_s.ce = chip_enable_req;
    next_s.tmr = s.tmr - 1'b1;
    case (s.fsm)
      SSP_IDLE: begin
        next_s.tmr = HALF_LAST;
        if (word_valid) begin
          // msb goes out first, so it is presented before the first rise
          next_s.shreg = word_data;
          next_s.bits_left = ssp_pkg::BIT_W'(ssp_pkg::WORD_W - 1);
          next_s.fsm = SSP_LOW;
        end
      end
      SSP_LOW: begin
        if (s.tmr == '0) begin
          next_s.sclk = 1'b1;
          next_s.tmr = HALF_LAST;
          next_s.fsm = SSP_HIGH;
        end
      end
      SSP_HIGH: begin
        if (s.tmr == '0) begin
          next_s.sclk = 1'b0;
          next_s.tmr = HALF_LAST;
          if (s.bits_left == '0) begin
            // strobe only after the last bit is in
            next_s.strobe = 1'b1;
            next_s.tmr = STRB_LAST;
            next_s.fsm = SSP_LOAD;
          end else begin
            next_s.shreg = {s.shreg[30:0], 1'b0};
            next_s.bits_left = s.bits_left - 1'b1;
            next_s.fsm = SSP_LOW;
          end
        end
      end
      SSP_LOAD: begin
        if (s.tmr == '0) begin
          next_s.strobe = 1'b0;
          next_s.fsm = SSP_IDLE;
        end
      end
      default: begin
        next_s.fsm = SSP_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      s <= '{fsm: SSP_IDLE, shreg: ssp_pkg::WORD_RESET, bits_left: '0, tmr: '0,
             sclk: 1'b0, strobe: 1'b0, ce: 1'b0};
    end else begin
      s <= next_s;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign word_ready = (s.fsm == SSP_IDLE);
  assign link.sclk = s.sclk;
  assign link.sdata = s.shreg[31];
  assign link.load_strobe = s.strobe;
  assign link.chip_enable = s.ce;

endmodule
`default_nettype wire
